// ===== rtl/ioad_pkg.sv
/*
  Constants and types for the I/O space access decoder.
  Assumes a core that sends one access request at a time.
*/
package ioad_pkg;

  // Direct, indirect and displaced forms all arrive as load or store
  typedef enum logic [2:0] {
    port_in_op,
    port_out_op,
    io_bit_set_op,
    io_bit_clear_op,
    skip_if_io_bit_set,
    skip_if_io_bit_clear,
    data_load_op,
    data_write_op
  } ioad_op_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_READ,
    SEQ_FIN
  } ioad_state_type;

  localparam logic [15:0] BIT_IO_LAST = 16'h001F;
  localparam logic [15:0] PORT_IO_LAST = 16'h003F;
  localparam logic [15:0] DATA_IO_FIRST = 16'h0020;
  localparam logic [15:0] DATA_IO_LAST = 16'h00FF;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] RSVD_FIRST = 8'hE0;
  // Data-space address of the block's own status flag register
  localparam logic [7:0] FLAG_DATA_ADDR = 8'h36;
  localparam logic [7:0] FLAG_RESET = 8'h00;

endpackage

// ===== rtl/ioad_flag_if.sv
/*
  Link between the access decoder and its status flag bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface ioad_flag_if;
  logic we;
  logic [7:0] wdata;
  logic [7:0] value;

  modport ctl (
    output we,
    output wdata,
    input value
  );

  modport bank (
    input we,
    input wdata,
    output value
  );
endinterface

// ===== rtl/ioad_flag_bank.sv
/*
  Eight write-one-to-clear status flags set by hardware events.
  Assumes events come from logic on the same clock.
*/
`timescale 1ns/100ps
module ioad_flag_bank
  import ioad_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Hardware events, one per flag
  input wire logic [7:0] i_evt,
  // Decoder side
  ioad_flag_if.bank fb
);

  logic [7:0] flag_r;
  logic [7:0] flag_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    if (fb.we)
    begin
      flag_nxt = flag_r & ~fb.wdata;
    end
    flag_nxt = flag_nxt | i_evt;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      flag_r <= FLAG_RESET;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  assign fb.value = flag_r;

endmodule

// ===== rtl/ioad_decoder.sv
/*
  Access decoder for the peripheral I/O register space.
  Assumes the register space answers a read in the cycle its read
  strobe is high, and that the core waits for o_ready.
*/
`timescale 1ns/100ps
module ioad_decoder
  import ioad_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Request from the core
  input wire logic i_req,
  input wire ioad_pkg::ioad_op_type i_op,
  input wire logic [15:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_wdata,
  // Answer to the core
  output logic o_ready,
  output logic o_done,
  output logic o_reject,
  output logic o_skip,
  output logic [7:0] o_rdata,
  // Peripheral register space
  output logic o_io_re,
  output logic o_io_we,
  output logic [7:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  // Status flag events
  input wire logic [7:0] i_flag_evt
);

  ioad_flag_if fif ();

  ioad_flag_bank i_ioad_flag_bank (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_evt(i_flag_evt),
    .fb(fif.bank)
  );

  ioad_state_type state_r;
  ioad_op_type op_r;
  logic [2:0] bit_r;
  logic flag_we_r;
  logic legal;
  logic io_form;
  logic write_only;
  logic [7:0] maddr;
  logic rsvd;
  logic is_flag;
  logic [7:0] rd_val;
  logic [7:0] bit_mask;

  // Classify the request and map it into data-space addressing
  always_comb
  begin
    io_form = (i_op != data_load_op) && (i_op != data_write_op);
    write_only = (i_op == port_out_op) || (i_op == data_write_op);
    maddr = i_addr[7:0];
    legal = 1'b0;
    if (io_form)
    begin
      maddr = i_addr[7:0] + IO_DATA_OFFSET;
    end
    case (i_op)
      port_in_op, port_out_op:
        legal = (i_addr <= PORT_IO_LAST);
      io_bit_set_op, io_bit_clear_op:
        legal = (i_addr <= BIT_IO_LAST);
      skip_if_io_bit_set, skip_if_io_bit_clear:
        legal = (i_addr <= BIT_IO_LAST);
      data_load_op, data_write_op:
        legal = (i_addr >= DATA_IO_FIRST) && (i_addr <= DATA_IO_LAST);
      default:
        legal = 1'b0;
    endcase
    // Extended range is never reached by the short forms
    if (io_form && (maddr >= EXT_FIRST))
    begin
      legal = 1'b0;
    end
    rsvd = (maddr >= RSVD_FIRST);
    is_flag = (maddr == FLAG_DATA_ADDR);
  end

  // Value seen in the read cycle, from the latched address
  always_comb
  begin
    bit_mask = 8'h01 << bit_r;
    if (o_io_addr >= RSVD_FIRST)
    begin
      rd_val = 8'h00;
    end
    else if (o_io_addr == FLAG_DATA_ADDR)
    begin
      rd_val = fif.value;
    end
    else
    begin
      rd_val = i_io_rdata;
    end
  end

  assign fif.we = flag_we_r;
  assign fif.wdata = o_io_wdata;

  // Sequencer
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= SEQ_IDLE;
      op_r <= port_in_op;
      bit_r <= 3'h0;
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_reject <= 1'b0;
      o_io_re <= 1'b0;
      o_io_we <= 1'b0;
      o_io_addr <= 8'h00;
      o_io_wdata <= 8'h00;
      flag_we_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        SEQ_IDLE:
        begin
          o_ready <= 1'b1;
          if (i_req && o_ready)
          begin
            o_ready <= 1'b0;
            op_r <= i_op;
            bit_r <= i_bit;
            o_io_addr <= maddr;
            if (!legal)
            begin
              o_done <= 1'b1;
              o_reject <= 1'b1;
              state_r <= SEQ_FIN;
            end
            else if (write_only)
            begin
              o_io_wdata <= i_wdata;
              // Reserved slots hold nothing, so the write is dropped
              o_io_we <= !rsvd && !is_flag;
              flag_we_r <= is_flag;
              o_done <= 1'b1;
              state_r <= SEQ_FIN;
            end
            else
            begin
              o_io_re <= !rsvd && !is_flag;
              state_r <= SEQ_READ;
            end
          end
        end
        SEQ_READ:
        begin
          o_io_re <= 1'b0;
          o_done <= 1'b1;
          state_r <= SEQ_FIN;
          case (op_r)
            io_bit_set_op, io_bit_clear_op:
            begin
              // Whole register written back: set flags read as one clear, except the bit that io_bit_clear_op names
              if (op_r == io_bit_set_op)
              begin
                o_io_wdata <= rd_val | bit_mask;
              end
              else
              begin
                o_io_wdata <= rd_val & ~bit_mask;
              end
              o_io_we <= (o_io_addr != FLAG_DATA_ADDR);
              flag_we_r <= (o_io_addr == FLAG_DATA_ADDR);
            end
            default:
            begin
              o_io_we <= 1'b0;
              flag_we_r <= 1'b0;
            end
          endcase
        end
        SEQ_FIN:
        begin
          o_done <= 1'b0;
          o_reject <= 1'b0;
          o_io_we <= 1'b0;
          flag_we_r <= 1'b0;
          o_ready <= 1'b1;
          state_r <= SEQ_IDLE;
        end
        default:
        begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Skip result and read data, taken in the read cycle
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_skip <= 1'b0;
      o_rdata <= 8'h00;
    end
    else if (state_r == SEQ_READ)
    begin
      case (op_r)
        skip_if_io_bit_set:
          o_skip <= rd_val[bit_r];
        skip_if_io_bit_clear:
          o_skip <= !rd_val[bit_r];
        port_in_op, data_load_op:
          o_rdata <= rd_val;
        default:
          o_skip <= 1'b0;
      endcase
    end
    else
    begin
      // The skip answer stands only beside o_done
      o_skip <= 1'b0;
    end
  end

endmodule

// ===== testbench/ioad_space_model.sv
/*
  Peripheral register space seen by the decoder.
  Assumes one write strobe per cycle and combinational reads.
*/
`timescale 1ns/100ps
module ioad_space_model (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [256];
  initial
  begin
    foreach (mem_r[k])
      mem_r[k] = 8'hC3;
  end
  // Plain always: the array is also preset by the initial block
  always @(posedge i_mclk)
  begin
    if (i_we)
      mem_r[i_addr] <= i_wdata;
  end
  assign o_rdata = mem_r[i_addr];
endmodule

// ===== testbench/ioad_decoder_properties.sv
/*
  Port-level properties of the access decoder.
  Assumes it is bound to ioad_decoder.
*/
`timescale 1ns/100ps
module ioad_checker
  import ioad_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire ioad_pkg::ioad_op_type i_op,
  input wire logic [15:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_io_rdata,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_reject,
  input wire logic o_skip,
  input wire logic [7:0] o_rdata,
  input wire logic o_io_re,
  input wire logic o_io_we,
  input wire logic [7:0] o_io_addr,
  input wire logic [7:0] o_io_wdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire tk = i_req && o_ready;
  wire lo = i_addr < 16'h0020 && i_addr != 16'h0016;
  wire rsv = i_addr inside {[16'h00E0:16'h00FF]};
  sequence s_rej;
    o_done && o_reject && !o_io_re && !o_io_we;
  endsequence
  sequence s_rd;
    o_io_re ##1 o_done;
  endsequence
  property p_bit;
    tk && i_op inside {io_bit_set_op, skip_if_io_bit_clear}
      && i_addr > 16'h001F |=> s_rej;
  endproperty
  a_bit: assert property (p_bit) else $error("bit op above 1F");
  property p_skip;
    tk && i_op == skip_if_io_bit_set && lo |=> s_rd ##0
      (($past(i_io_rdata) >> $past(i_bit, 2)) & 8'h01) == {7'h00, o_skip};
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  property p_rmw;
    tk && i_op == io_bit_set_op && lo |=> s_rd ##0 o_io_we
      && o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_bit, 2)));
  endproperty
  a_rmw: assert property (p_rmw) else $error("bit set wrong");
  property p_port;
    tk && i_op == port_in_op && i_addr > 16'h003F |=> s_rej;
  endproperty
  a_port: assert property (p_port) else $error("port above 3F");
  property p_map;
    tk && i_op == port_out_op && i_addr < 16'h0040 && i_addr != 16'h0016
      |=> o_io_we && o_io_addr == $past(i_addr[7:0]) + 8'h20;
  endproperty
  a_map: assert property (p_map) else $error("port map wrong");
  property p_ext;
    tk && i_op == data_load_op && i_addr inside {[16'h0060:16'h00DF]}
      |=> o_io_addr == $past(i_addr[7:0]) ##0 s_rd;
  endproperty
  a_ext: assert property (p_ext) else $error("ext load wrong");
  property p_rsv_wr;
    tk && i_op == data_write_op && rsv |=> o_done && !o_io_we && !o_reject;
  endproperty
  a_rsv_wr: assert property (p_rsv_wr) else $error("rsvd write");
  property p_rsv_rd;
    tk && i_op == data_load_op && rsv |=> !o_io_re ##1 o_done
      && o_rdata == 8'h00;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("rsvd read");
endmodule
bind ioad_decoder ioad_checker i_ioad_checker (.*);

// ===== testbench/io_space_access_decoder_bench.sv
/*
  Self-checking bench for the access decoder.
  Assumes the register space model and the bound checker.
*/
`timescale 1ns/100ps
module io_space_access_decoder_bench;
  import ioad_pkg::*;
  typedef struct packed {
    ioad_op_type op;
    logic [7:0] a;
    logic [2:0] b;
    logic [7:0] w;
    logic rj;
    logic sk;
    logic [7:0] rd;
  } ioad_row_type;
  ioad_row_type rows [16] = '{
    '{port_out_op, 8'h05, 3'h0, 8'hA5, 1'h0, 1'h0, 8'h00},
    '{port_in_op, 8'h05, 3'h0, 8'h00, 1'h0, 1'h0, 8'hA5},
    '{data_load_op, 8'h25, 3'h0, 8'h00, 1'h0, 1'h0, 8'hA5},
    '{port_in_op, 8'h40, 3'h0, 8'h00, 1'h1, 1'h0, 8'hA5},
    '{io_bit_set_op, 8'h05, 3'h1, 8'h00, 1'h0, 1'h0, 8'h00},
    '{io_bit_clear_op, 8'h05, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00},
    '{data_load_op, 8'h25, 3'h0, 8'h00, 1'h0, 1'h0, 8'hA6},
    '{io_bit_set_op, 8'h20, 3'h0, 8'h00, 1'h1, 1'h0, 8'h00},
    '{skip_if_io_bit_set, 8'h05, 3'h1, 8'h00, 1'h0, 1'h1, 8'h00},
    '{skip_if_io_bit_clear, 8'h05, 3'h0, 8'h00, 1'h0, 1'h1, 8'h00},
    '{skip_if_io_bit_set, 8'h05, 3'h3, 8'h00, 1'h0, 1'h0, 8'h00},
    '{skip_if_io_bit_clear, 8'h60, 3'h0, 8'h00, 1'h1, 1'h0, 8'h00},
    '{data_write_op, 8'h80, 3'h0, 8'h3C, 1'h0, 1'h0, 8'h00},
    '{data_load_op, 8'h80, 3'h0, 8'h00, 1'h0, 1'h0, 8'h3C},
    '{data_write_op, 8'hE5, 3'h0, 8'hFF, 1'h0, 1'h0, 8'h00},
    '{data_load_op, 8'hE5, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00}};
  logic i_mclk, i_nrst, i_req, o_ready, o_done, o_reject, o_skip;
  logic o_io_re, o_io_we, rj_q, sk_q;
  ioad_op_type i_op;
  logic [15:0] i_addr;
  logic [2:0] i_bit;
  logic [7:0] i_wdata, o_rdata, o_io_addr, o_io_wdata, i_io_rdata;
  logic [7:0] i_flag_evt, rd_q;
  int err_count = 0;
  int tests_run = 0;
  ioad_decoder i_ioad_decoder (.*);
  ioad_space_model i_ioad_space_model (.i_mclk(i_mclk), .i_we(o_io_we),
    .i_addr(o_io_addr), .i_wdata(o_io_wdata), .o_rdata(i_io_rdata));
  initial
  begin
    i_mclk = 1'h0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic acc(input ioad_op_type op, input logic [15:0] a,
    input logic [2:0] b, input logic [7:0] w);
    int n;
    i_op = op;
    i_addr = a;
    i_bit = b;
    i_wdata = w;
    i_req = 1'h1;
    @(posedge i_mclk) #1;
    i_req = 1'h0;
    for (n = 0; n < 8 && o_done !== 1'h1; n++)
      @(posedge i_mclk) #1;
    {rj_q, sk_q, rd_q} = {o_reject, o_skip, o_rdata};
    @(posedge i_mclk) #1;
    chk({7'h00, o_ready}, 8'h01);
    if (n == 8)
    begin
      err_count++;
      complete_run;
    end
  endtask
  task automatic rst;
    i_nrst = 1'h0;
    repeat (16) @(posedge i_mclk) #1;
    chk({o_ready, o_done, o_reject, o_skip, o_io_re, o_io_we, 2'h0}, 8'h00);
    i_nrst = 1'h1;
    @(posedge i_mclk) #1;
  endtask
  initial
  begin
    i_op = port_in_op;
    {i_req, i_addr, i_bit, i_wdata, i_flag_evt} = '0;
    rst;
    foreach (rows[k])
    begin
      acc(rows[k].op, {8'h00, rows[k].a}, rows[k].b, rows[k].w);
      chk({6'h00, rj_q, sk_q}, {6'h00, rows[k].rj, rows[k].sk});
      if (rows[k].op inside {port_in_op, data_load_op})
        chk(rd_q, rows[k].rd);
    end
    acc(data_load_op, 16'h001F, 3'h0, 8'h00);
    chk({7'h00, rj_q}, 8'h01);
    i_flag_evt = 8'h09;
    @(posedge i_mclk) #1;
    i_flag_evt = 8'h00;
    acc(data_load_op, 16'h0036, 3'h0, 8'h00);
    chk(rd_q, 8'h09);
    acc(data_write_op, 16'h0036, 3'h0, 8'h01);
    acc(data_load_op, 16'h0036, 3'h0, 8'h00);
    chk(rd_q, 8'h08);
    acc(io_bit_set_op, 16'h0016, 3'h1, 8'h00);
    acc(data_load_op, 16'h0036, 3'h0, 8'h00);
    chk(rd_q, 8'h00);
    i_req = 1'h1;
    i_flag_evt = 8'h40;
    @(posedge i_mclk) #1;
    i_req = 1'h0;
    i_flag_evt = 8'h00;
    rst;
    acc(data_load_op, 16'h0036, 3'h0, 8'h00);
    chk(rd_q, 8'h00);
    acc(port_in_op, 16'h0005, 3'h0, 8'h00);
    chk(rd_q, 8'hA6);
    complete_run;
  end
endmodule
